// ### logic/fhp_consts.vh
// constants for the framer host bus port
// assumes inclusion by bare name from every design file of the port
`ifndef FHP_CONSTS_VH
`define FHP_CONSTS_VH

// clock and timing
`define FHP_CLK_PERIOD_NS 100
`define FHP_SEC_PERIOD_NS 1000000000
`define FHP_SEC_CNT_W 30
`define FHP_RST_MIN_CYCLES 2
`define FHP_SYSCLK_KHZ 32768
`define FHP_MCLK_MIN_KHZ 8000
`define FHP_MCLK_MAX_KHZ 36000

// bus geometry
`define FHP_DATA_W 8
`define FHP_ADDR_W 12
`define FHP_QUAD_ADDR_W 11
`define FHP_ADDR_HI_LSB 8
`define FHP_REG_AW 6

// bus style, direction and sync select encodings
`define FHP_STYLE_SEP 1'b0
`define FHP_STYLE_MUX 1'b1
`define FHP_DIR_READ 1'b1
`define FHP_SYNC_ON 1'b1

// second tick control word
`define FHP_ADDR_SEC_CTRL 12'hFFF
`define FHP_SEC_DIR_BIT 0
`define FHP_SEC_LVL_BIT 1
`define FHP_SEC_DIR_RESET 1'b0

// register reset value
`define FHP_REG_RESET 8'h00

`endif

// ### logic/fhp_host_port.v
// parallel 8-bit host processor port with two framer groups
// assumes all pins arrive synchronous to core_clk; mclk_in is sampled as data
//
// Function
// - reset cycle restores registers, pins to input except acknowledge outputs
// - internal power-on reset acts like reset pin
// - sync select high uses processor clock
// - sync select low: strobes act without clock
// - sync select high: sample strobes on clock rise
// - separate style: address pins, data strobe, direction
// - multiplexed style: address byte on bus, rd/wr
// - quad variant decodes eleven address bits
// - address strobe fall captures and holds address
// - chip select high ends cycle, floats bus
// - x16 variant: one select per framer group
// - second pin input aligns interval to rise
// - second pin output rises at interval start
// - open-drain interrupt low while requests pending
// - x16 variant: per-group second, irq, ack pins
// - acknowledge low while strobe and select low
`include "fhp_consts.vh"

module fhp_host_port #(
    parameter QUAD = 0,
    parameter X16 = 1,
    parameter [`FHP_SEC_CNT_W-1:0] SEC_CYCLES = `FHP_SEC_PERIOD_NS / `FHP_CLK_PERIOD_NS
) (
    // clock and power-on reset
    input wire core_clk,
    input wire sys_rst,
    // hardware reset pin and clocks
    input wire hw_reset_n,
    input wire system_clock_in,
    input wire mclk_in,
    // mode straps
    input wire sync_bus_select,
    input wire bus_style_select,
    // address and strobes
    input wire [`FHP_ADDR_W-1:0] addr_in,
    input wire address_latch_strobe_n,
    input wire chip_select_low_group_n,
    input wire chip_select_high_group_n,
    input wire data_strobe_n,
    input wire read_write_n,
    // data bus
    input wire [`FHP_DATA_W-1:0] ad_in,
    output wire [`FHP_DATA_W-1:0] ad_out,
    output wire ad_oe,
    // interrupt sources from the framers
    input wire irq_pending_low,
    input wire irq_pending_high,
    // open-drain interrupt outputs
    output wire irq_request_low_n_out,
    output wire irq_request_low_n_oe,
    output wire irq_request_high_n_out,
    output wire irq_request_high_n_oe,
    // open-drain acknowledge outputs
    output wire transfer_ack_low_n_out,
    output wire transfer_ack_low_n_oe,
    output wire transfer_ack_high_n_out,
    output wire transfer_ack_high_n_oe,
    // second tick pins
    input wire second_tick_low_in,
    output wire second_tick_low_out,
    output wire second_tick_low_oe,
    input wire second_tick_high_in,
    output wire second_tick_high_out,
    output wire second_tick_high_oe,
    // interval start status
    output wire second_start_low,
    output wire second_start_high
);

    localparam AW = `FHP_ADDR_W;
    localparam DW = `FHP_DATA_W;
    localparam RAW = `FHP_REG_AW;

    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_READ = 2'b01;
    localparam [1:0] ST_WRITE = 2'b10;
    localparam [1:0] ST_DONE = 2'b11;

    // read request for either bus style
    function rd_req;
        input style;
        input ds_n;
        input rw;
        begin
            if (style == `FHP_STYLE_MUX)
                rd_req = ~ds_n;
            else
                rd_req = ~ds_n & (rw == `FHP_DIR_READ);
        end
    endfunction

    // write request for either bus style
    function wr_req;
        input style;
        input ds_n;
        input rw;
        begin
            if (style == `FHP_STYLE_MUX)
                wr_req = ~rw;
            else
                wr_req = ~ds_n & (rw != `FHP_DIR_READ);
        end
    endfunction

    reg hw_rst_r;
    wire rst;
    reg mclk_prev_r;
    reg as_prev_r;
    reg [AW-1:0] addr_r;
    reg [AW-1:0] addr_nxt;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg grp_r;
    reg [DW-1:0] wdata_r;
    reg [DW-1:0] ad_out_r;
    reg [1:0] sec_dir_r;
    wire sample_en;
    wire as_fall;
    wire cs_low;
    wire cs_high;
    wire cs_any;
    wire grp_now;
    wire grp_sel;
    wire rd_now;
    wire wr_now;
    wire is_ctrl;
    wire mapped;
    wire [RAW:0] bank_addr;
    wire [DW-1:0] bank_rd;
    wire [DW-1:0] rd_word;
    wire tick_low_lvl;
    wire tick_high_lvl;

    // power-on reset or a low hardware reset pin
    always @(posedge core_clk)
    begin
        hw_rst_r <= ~hw_reset_n;
    end

    assign rst = sys_rst | hw_rst_r;

    // strobes sampled on processor clock rise, or every cycle
    assign sample_en = (sync_bus_select == `FHP_SYNC_ON) ? (mclk_in & ~mclk_prev_r) : 1'b1;

    assign as_fall = as_prev_r & ~address_latch_strobe_n;
    assign cs_low = ~chip_select_low_group_n;
    assign cs_high = (X16 != 0) & ~chip_select_high_group_n;
    assign cs_any = cs_low | cs_high;
    assign grp_now = ~cs_low & cs_high;
    assign rd_now = rd_req(bus_style_select, data_strobe_n, read_write_n);
    assign wr_now = wr_req(bus_style_select, data_strobe_n, read_write_n);

    // address capture for both bus styles
    always @*
    begin
        addr_nxt = addr_r;
        if (as_fall)
        begin
            if (bus_style_select == `FHP_STYLE_MUX)
                addr_nxt = {addr_in[AW-1:`FHP_ADDR_HI_LSB], ad_in};
            else
                addr_nxt = addr_in;
            if (QUAD != 0)
                addr_nxt[AW-1] = 1'b0;
        end
    end

    assign is_ctrl = (addr_r == `FHP_ADDR_SEC_CTRL);
    assign mapped = (addr_r[AW-1:RAW] == {(AW-RAW){1'b0}});
    // group of the cycle being entered, or of the one in progress
    assign grp_sel = (state_r == ST_IDLE) ? grp_now : grp_r;
    assign bank_addr = {grp_sel, addr_r[RAW-1:0]};
    assign tick_low_lvl = second_tick_low_oe ? second_tick_low_out : second_tick_low_in;
    assign tick_high_lvl = second_tick_high_oe ? second_tick_high_out : second_tick_high_in;

    // word returned to the host
    assign rd_word = is_ctrl ?
        {{(DW-2){1'b0}}, (grp_sel ? tick_high_lvl : tick_low_lvl), sec_dir_r[grp_sel]} :
        (mapped ? bank_rd : {DW{1'b0}});

    // transfer cycle sequencing
    always @*
    begin
        state_nxt = state_r;
        if (!cs_any)
        begin
            state_nxt = ST_IDLE;
        end
        else if (sample_en)
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (rd_now)
                        state_nxt = ST_READ;
                    else if (wr_now)
                        state_nxt = ST_WRITE;
                end
                ST_READ:
                begin
                    if (!rd_now)
                        state_nxt = ST_IDLE;
                end
                ST_WRITE:
                begin
                    state_nxt = ST_DONE;
                end
                ST_DONE:
                begin
                    if (!wr_now)
                        state_nxt = ST_IDLE;
                end
                default:
                begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
        else if (state_r == ST_WRITE)
        begin
            state_nxt = ST_DONE;
        end
    end

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            mclk_prev_r <= 1'b0;
            as_prev_r <= 1'b1;
            addr_r <= {AW{1'b0}};
            state_r <= ST_IDLE;
            grp_r <= 1'b0;
            wdata_r <= {DW{1'b0}};
            ad_out_r <= {DW{1'b0}};
            sec_dir_r <= {2{`FHP_SEC_DIR_RESET}};
        end
        else
        begin
            mclk_prev_r <= mclk_in;
            as_prev_r <= address_latch_strobe_n;
            addr_r <= addr_nxt;
            state_r <= state_nxt;
            if (state_r == ST_IDLE && state_nxt != ST_IDLE)
            begin
                grp_r <= grp_now;
                wdata_r <= ad_in;
            end
            if (state_r == ST_READ || state_nxt == ST_READ)
                ad_out_r <= rd_word;
            if (state_r == ST_WRITE && is_ctrl)
                sec_dir_r[grp_r] <= wdata_r[`FHP_SEC_DIR_BIT];
        end
    end

    // data bus driven only in a selected read
    assign ad_out = ad_out_r;
    assign ad_oe = (state_r == ST_READ) & cs_any;

    fhp_reg_bank #(
        .AW(RAW + 1),
        .DW(DW)
    ) u_bank (
        .core_clk(core_clk),
        .rst(rst),
        .wr_en((state_r == ST_WRITE) & mapped),
        .wr_addr(bank_addr),
        .wr_data(wdata_r),
        .rd_addr(bank_addr),
        .rd_data(bank_rd)
    );

    fhp_sec_timer #(
        .CNT_W(`FHP_SEC_CNT_W),
        .SEC_CYCLES(SEC_CYCLES)
    ) u_sec_low (
        .core_clk(core_clk),
        .rst(rst),
        .dir_out(sec_dir_r[0]),
        .tick_in(second_tick_low_in),
        .tick_out(second_tick_low_out),
        .tick_oe(second_tick_low_oe),
        .interval_start_r(second_start_low)
    );

    fhp_sec_timer #(
        .CNT_W(`FHP_SEC_CNT_W),
        .SEC_CYCLES(SEC_CYCLES)
    ) u_sec_high (
        .core_clk(core_clk),
        .rst(rst),
        .dir_out(sec_dir_r[1] & (X16 != 0)),
        .tick_in(second_tick_high_in),
        .tick_out(second_tick_high_out),
        .tick_oe(second_tick_high_oe),
        .interval_start_r(second_start_high)
    );

    // open-drain interrupt and acknowledge, pulled low when enabled
    assign irq_request_low_n_out = 1'b0;
    assign irq_request_low_n_oe = irq_pending_low & ~rst;
    assign irq_request_high_n_out = 1'b0;
    assign irq_request_high_n_oe = irq_pending_high & (X16 != 0) & ~rst;
    assign transfer_ack_low_n_out = 1'b0;
    assign transfer_ack_low_n_oe = ~address_latch_strobe_n & cs_low;
    assign transfer_ack_high_n_out = 1'b0;
    assign transfer_ack_high_n_oe = ~address_latch_strobe_n & cs_high;

endmodule // fhp_host_port

// ### logic/fhp_reg_bank.v
// framer register storage behind the host port, two groups of words
// assumes one write per cycle and a combinational read of the addressed word
`include "fhp_consts.vh"

module fhp_reg_bank #(
    parameter AW = `FHP_REG_AW + 1,
    parameter DW = `FHP_DATA_W
) (
    // clock and reset
    input wire core_clk,
    input wire rst,
    // write side
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    // read side
    input wire [AW-1:0] rd_addr,
    output wire [DW-1:0] rd_data
);

    localparam DEPTH = 1 << AW;

    reg [DW-1:0] mem_r [0:DEPTH-1];
    integer i;

    // every word back to its power-up value on reset
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            for (i = 0; i < DEPTH; i = i + 1)
                mem_r[i] <= `FHP_REG_RESET;
        end
        else if (wr_en)
        begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem_r[rd_addr];

endmodule // fhp_reg_bank

// ### logic/fhp_sec_timer.v
// one-second status interval timer for one framer group
// assumes tick_in is synchronous to core_clk
`include "fhp_consts.vh"

module fhp_sec_timer #(
    parameter CNT_W = `FHP_SEC_CNT_W,
    parameter [CNT_W-1:0] SEC_CYCLES = `FHP_SEC_PERIOD_NS / `FHP_CLK_PERIOD_NS
) (
    // clock and reset
    input wire core_clk,
    input wire rst,
    // direction, high drives the pin
    input wire dir_out,
    // pin
    input wire tick_in,
    output wire tick_out,
    output wire tick_oe,
    // status
    output reg interval_start_r
);

    localparam [CNT_W-1:0] LAST = SEC_CYCLES - {{(CNT_W-1){1'b0}}, 1'b1};
    localparam [CNT_W-1:0] HALF = SEC_CYCLES >> 1;

    reg [CNT_W-1:0] cnt_r;
    reg [CNT_W-1:0] cnt_nxt;
    reg tick_prev_r;
    reg tick_out_r;
    reg start_nxt;
    wire tick_rise;

    assign tick_rise = tick_in & ~tick_prev_r;

    always @*
    begin
        cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        start_nxt = 1'b0;
        if (!dir_out && tick_rise)
        begin
            cnt_nxt = {CNT_W{1'b0}};
            start_nxt = 1'b1;
        end
        else if (cnt_r == LAST)
        begin
            cnt_nxt = {CNT_W{1'b0}};
            start_nxt = 1'b1;
        end
    end

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            cnt_r <= {CNT_W{1'b0}};
            tick_prev_r <= 1'b0;
            tick_out_r <= 1'b0;
            interval_start_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick_prev_r <= tick_in;
            interval_start_r <= start_nxt;
            // high for the first half, so the rise marks the interval start
            tick_out_r <= (cnt_nxt < HALF);
        end
    end

    assign tick_out = tick_out_r;
    assign tick_oe = dir_out;

endmodule // fhp_sec_timer

// ### verification/fhp_host_model.sv
// host processor model driving the port's bus pins
// assumes a free-running core clock and one transfer at a time
module fhp_host_model (
    // clock and read answer
    input wire logic clk,
    input wire logic rd_oe,
    // mode straps and processor clock
    output logic sync_sel,
    output logic style_sel,
    output logic mclk,
    // address, strobes and data
    output logic as_n,
    output logic cs_lo_n,
    output logic cs_hi_n,
    output logic ds_n,
    output logic rw_n,
    output logic [11:0] addr,
    output logic [7:0] ad
);
    timeunit 1ns;
    timeprecision 1ns;
    logic idle = 1'b1;
    initial
    begin
        {sync_sel, style_sel, mclk} = 3'h0;
        {as_n, cs_lo_n, cs_hi_n, ds_n, rw_n} = 5'h1F;
        addr = 12'h000;
        ad = 8'hA5;
    end
    // processor clock runs free; released data lines keep changing
    always @(posedge clk)
    begin
        mclk <= ~mclk;
        if (idle)
            ad <= ~ad;
    end
    task automatic xfer(input logic s, st, g, wr, input logic [11:0] a, input logic [7:0] d);
        idle = 1'b0;
        @(posedge clk);
        sync_sel <= s;
        style_sel <= st;
        as_n <= 1'b0;
        addr <= a;
        if (st)
            ad <= a[7:0];
        @(posedge clk);
        cs_lo_n <= g;
        cs_hi_n <= ~g;
        ds_n <= st & wr;
        rw_n <= ~wr;
        if (wr)
            ad <= d;
        if (wr)
            repeat (6) @(posedge clk);
        else
            for (int i = 0; i < 20 && !rd_oe; i++)
            begin
                @(posedge clk);
                #1;
            end
        @(posedge clk);
        {as_n, cs_lo_n, cs_hi_n, ds_n, rw_n} <= 5'h1F;
        repeat (2) @(posedge clk);
        idle = 1'b1;
    endtask
endmodule // fhp_host_model

// ### verification/fhp_host_port_properties.sv
// checker for the host port pins
// assumes a bind to fhp_host_port with the same SEC_CYCLES
`include "fhp_consts.vh"
module fhp_host_port_properties #(
    parameter [`FHP_SEC_CNT_W-1:0] SEC_CYCLES = 20
) (
    // clock and resets
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic hw_reset_n,
    // strobes
    input wire logic bus_style_select,
    input wire logic address_latch_strobe_n,
    input wire logic chip_select_low_group_n,
    input wire logic chip_select_high_group_n,
    input wire logic data_strobe_n,
    input wire logic read_write_n,
    // outputs and status
    input wire logic ad_oe,
    input wire logic irq_pending_low,
    input wire logic irq_request_low_n_oe,
    input wire logic irq_pending_high,
    input wire logic irq_request_high_n_oe,
    input wire logic transfer_ack_low_n_oe,
    input wire logic transfer_ack_high_n_oe,
    input wire logic second_tick_low_in,
    input wire logic second_tick_low_oe,
    input wire logic second_start_low
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [31:0] gap_r;
    logic seen_r;
    // cycles since the last interval start
    always @(posedge core_clk)
    begin
        if (sys_rst || !hw_reset_n)
        begin
            gap_r <= 32'h1;
            seen_r <= 1'b0;
        end
        else if (second_start_low)
        begin
            gap_r <= 32'h1;
            seen_r <= 1'b1;
        end
        else
            gap_r <= gap_r + 32'h1;
    end
    a_ack_low: assert property (transfer_ack_low_n_oe ==
        (!address_latch_strobe_n && !chip_select_low_group_n))
        else $error("low group acknowledge wrong");
    a_ack_high: assert property (transfer_ack_high_n_oe ==
        (!address_latch_strobe_n && !chip_select_high_group_n))
        else $error("high group acknowledge wrong");
    a_irq_set: assert property (irq_pending_low && $past(hw_reset_n) |-> irq_request_low_n_oe)
        else $error("interrupt not driven");
    a_irq_clear: assert property (!irq_pending_low |-> !irq_request_low_n_oe)
        else $error("interrupt not released");
    a_irq_high: assert property ($past(hw_reset_n) |-> irq_request_high_n_oe == irq_pending_high)
        else $error("high group interrupt wrong");
    a_bus_float: assert property (chip_select_low_group_n && chip_select_high_group_n |-> !ad_oe)
        else $error("bus driven without select");
    a_read_cause: assert property ($rose(ad_oe) |->
        $past(!data_strobe_n && (bus_style_select || read_write_n)))
        else $error("bus driven without read");
    a_sec_spacing: assert property (second_start_low && seen_r && second_tick_low_oe
        && $past(second_tick_low_oe) |-> gap_r == 32'(SEC_CYCLES))
        else $error("interval length wrong");
    a_tick_align: assert property (!second_tick_low_oe && second_tick_low_in && !$past(second_tick_low_in)
        |=> second_start_low)
        else $error("interval not aligned");
    c_read: cover property ($rose(ad_oe));
    c_ack_high: cover property (transfer_ack_high_n_oe);
    c_sec_out: cover property (second_start_low && second_tick_low_oe);
endmodule // fhp_host_port_properties

// ### verification/framer_host_bus_port_bench.sv
// top bench for the host port with a host model and a checker
// assumes the design sources and their include path are given
module framer_host_bus_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam SEC = 20;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hw_reset_n = 1'b1;
    logic [1:0] irq = 2'h0;
    logic tick_drv = 1'b0;
    logic oe_q = 1'b0;
    logic [31:0] seed = 32'h19;
    logic [7:0] mem [0:127];
    logic [7:0] exp_q [$];
    int n_errors = 0;
    int samples_checked = 0;
    wire sync_sel, style_sel, mclk, as_n, cs_lo_n, cs_hi_n, ds_n, rw_n;
    wire ad_oe, t_lo_oe, t_lo, t_hi_oe, t_hi, start_lo;
    wire [11:0] addr;
    wire [7:0] ad, ad_out;
    wire t_lo_w = t_lo_oe ? t_lo : tick_drv;
    wire t_hi_w = t_hi_oe ? t_hi : tick_drv;
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) irq <= irq + 2'h1;
    fhp_host_model fhp_host_model_inst (.clk(core_clk), .rd_oe(ad_oe), .sync_sel(sync_sel),
        .style_sel(style_sel), .mclk(mclk), .as_n(as_n), .cs_lo_n(cs_lo_n), .cs_hi_n(cs_hi_n),
        .ds_n(ds_n), .rw_n(rw_n), .addr(addr), .ad(ad));
    fhp_host_port #(.SEC_CYCLES(SEC)) fhp_host_port_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .hw_reset_n(hw_reset_n), .system_clock_in(core_clk), .mclk_in(mclk),
        .sync_bus_select(sync_sel), .bus_style_select(style_sel), .addr_in(addr),
        .address_latch_strobe_n(as_n), .chip_select_low_group_n(cs_lo_n),
        .chip_select_high_group_n(cs_hi_n), .data_strobe_n(ds_n), .read_write_n(rw_n), .ad_in(ad),
        .ad_out(ad_out), .ad_oe(ad_oe), .irq_pending_low(irq[0]), .irq_pending_high(irq[1]),
        .irq_request_low_n_out(), .irq_request_low_n_oe(), .irq_request_high_n_out(),
        .irq_request_high_n_oe(), .transfer_ack_low_n_out(), .transfer_ack_low_n_oe(),
        .transfer_ack_high_n_out(), .transfer_ack_high_n_oe(), .second_tick_low_in(t_lo_w),
        .second_tick_low_out(t_lo), .second_tick_low_oe(t_lo_oe), .second_tick_high_in(t_hi_w),
        .second_tick_high_out(t_hi), .second_tick_high_oe(t_hi_oe), .second_start_low(start_lo),
        .second_start_high());
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            n_errors++;
            $display("wrong value at %0t ns: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic finish_test();
        if (n_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic rd(input logic s, st, g, input logic [11:0] a);
        exp_q.push_back(a[11:6] == 6'h00 ? mem[{g, a[5:0]}] : 8'h00);
        fhp_host_model_inst.xfer(s, st, g, 1'b0, a, 8'h00);
    endtask
    // each new read answer is matched to the oldest note
    always @(posedge core_clk)
    begin
        oe_q <= ad_oe;
        if (ad_oe && !oe_q)
            check(ad_out, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
    end
    initial
    begin
        repeat (8000) @(posedge core_clk);
        n_errors++;
        finish_test();
    end
    initial
    begin
        logic [31:0] r;
        logic [11:0] a;
        logic [1:0] tp;
        int n;
        int m;
        for (int i = 0; i < 128; i++)
            mem[i] = 8'h00;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(1'b0, 1'b0, 1'b0, 12'h005);
        rd(1'b1, 1'b1, 1'b1, 12'h03F);
        for (int i = 0; i < 40; i++)
        begin
            r = rnd();
            a = {5'h00, r[8], r[14:9]};
            fhp_host_model_inst.xfer(r[0], r[1], r[2], 1'b1, a, r[23:16]);
            if (!r[8])
                mem[{r[2], a[5:0]}] = r[23:16];
            rd(r[3], r[4], r[2], a);
        end
        fhp_host_model_inst.xfer(1'b0, 1'b0, 1'b0, 1'b1, 12'hFFF, 8'h01);
        fhp_host_model_inst.xfer(1'b1, 1'b1, 1'b1, 1'b1, 12'hFFF, 8'h01);
        n = 0;
        m = 0;
        tp = {t_hi, t_lo};
        repeat (60)
        begin
            @(posedge core_clk);
            n += start_lo;
            m += int'(t_lo && !tp[0]) + int'(t_hi && !tp[1]);
            tp = {t_hi, t_lo};
        end
        check(8'(n), 8'h03);
        check(8'(m), 8'h06);
        check({6'h00, t_hi_oe, t_lo_oe}, 8'h03);
        @(posedge core_clk);
        hw_reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        hw_reset_n <= 1'b1;
        for (int i = 0; i < 128; i++)
            mem[i] = 8'h00;
        rd(1'b0, 1'b0, r[2], {6'h00, a[5:0]});
        check({6'h00, t_hi_oe, t_lo_oe}, 8'h00);
        tick_drv <= 1'b1;
        repeat (3) @(posedge core_clk);
        tick_drv <= 1'b0;
        repeat (4) @(posedge core_clk);
        check(8'(exp_q.size()), 8'h00);
        finish_test();
    end
endmodule // framer_host_bus_port_bench
bind fhp_host_port fhp_host_port_properties #(.SEC_CYCLES(SEC_CYCLES)) fhp_host_port_properties_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .hw_reset_n(hw_reset_n), .bus_style_select(bus_style_select),
    .address_latch_strobe_n(address_latch_strobe_n), .chip_select_low_group_n(chip_select_low_group_n),
    .chip_select_high_group_n(chip_select_high_group_n), .data_strobe_n(data_strobe_n),
    .read_write_n(read_write_n), .ad_oe(ad_oe), .irq_pending_low(irq_pending_low),
    .irq_request_low_n_oe(irq_request_low_n_oe), .transfer_ack_low_n_oe(transfer_ack_low_n_oe),
    .irq_pending_high(irq_pending_high), .irq_request_high_n_oe(irq_request_high_n_oe),
    .transfer_ack_high_n_oe(transfer_ack_high_n_oe), .second_tick_low_in(second_tick_low_in),
    .second_tick_low_oe(second_tick_low_oe), .second_start_low(second_start_low));
